// ### src/pso_pkg.sv
/*
 * Package for the eight-stage parallel-in / serial-out shifter: sizes,
 * reset values and the bundle of synchronised pin levels.
 * Assumes it is compiled before every other file of the block.
 */
package pso_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int PSO_STAGES     = 8;
    localparam int PSO_LAST       = PSO_STAGES - 1;
    localparam int PSO_FIFO_WIDTH = 1;
    localparam int PSO_FIFO_DEPTH = 8;

    // ----------------------------------------------------------------
    // Values after reset
    // ----------------------------------------------------------------
    localparam logic [PSO_STAGES-1:0] PSO_STAGE_RST = 8'h00;

    typedef struct packed {
        logic                  clock_in;
        logic                  clock_gate;
        logic                  shift_sel;
        logic                  serial_in;
        logic [PSO_STAGES-1:0] par_in;
    } pso_pins_t;

    // Clock pins rest high so the internal clock sees no edge at release
    localparam pso_pins_t PSO_PINS_RST = '{clock_in: 1'b1, clock_gate: 1'b1, shift_sel: 1'b0,
                                           serial_in: 1'b0, par_in: 8'h00};

endpackage

// ### src/pso_fifo.sv
/*
 * Small shift-down FIFO with valid/ready on both sides.
 * Head entry, valid and ready all come straight from flip-flops.
 * Assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module pso_fifo #(
    parameter int W = 1,
    parameter int D = 8
) (
    input  wire logic         clk_sys,   // System clock
    input  wire logic         reset_n,   // Async reset, active low
    input  wire logic         in_valid,  // Producer offers a word
    output logic              in_ready,  // Room for a word
    input  wire logic [W-1:0] in_data,   // Word offered
    output logic              out_valid, // Head word present
    input  wire logic         out_ready, // Consumer takes the head
    output logic [W-1:0]      out_data   // Head word
);

    localparam int CW = $clog2(D + 1);

    logic [W-1:0]  mem_q [D];
    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    logic          push;
    logic          pop;

    assign push     = in_valid & in_ready;
    assign pop      = out_valid & out_ready;
    assign out_data = mem_q[0];
    assign count_d  = count_q + CW'(push) - CW'(pop);

    // ----------------------------------------------------------------
    // Entries: shift down on pop, write at the tail on push
    // ----------------------------------------------------------------
    for (genvar i = 0; i < D; i++) begin : g_entry
        always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
                mem_q[i] <= '0;
            end else if (pop) begin
                if (push && CW'(i) == count_q - CW'(1)) begin
                    mem_q[i] <= in_data;
                end else if (i < D - 1) begin
                    mem_q[i] <= mem_q[(i < D - 1) ? i + 1 : i];
                end
            end else if (push && CW'(i) == count_q) begin
                mem_q[i] <= in_data;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            count_q   <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            count_q   <= count_d;
            in_ready  <= count_d != CW'(D);
            out_valid <= count_d != '0;
        end
    end

    property p_fifo_bound;
        @(posedge clk_sys) disable iff (!reset_n) count_q <= CW'(D);
    endproperty
    a_fifo_bound: assert property (p_fifo_bound) else $error("fifo count above depth");

    property p_fifo_full_stalls;
        @(posedge clk_sys) disable iff (!reset_n) (!in_ready && !pop) |=> count_q == $past(count_q);
    endproperty
    a_fifo_full_stalls: assert property (p_fifo_full_stalls) else $error("fifo grew while full");

endmodule

`default_nettype wire

// ### src/pso_shifter.sv
/*
 * Eight-stage shifter with parallel load, gated clock and direct clear.
 * Bits leaving the last stage on a shift are queued in an eight-word FIFO.
 * Assumes all device pins are asynchronous to clk_sys and change far
 * slower than clk_sys (each pin level must hold three clk_sys cycles).
 */
// What this block does
// - Shift select high: each qualified edge with room in the queue shifts all stages, serial bit enters first.
// - Shift select low: parallel inputs load on the next qualified edge.
// - During parallel load the serial input is ignored.
// - Register acts on the rising edge of NOR of clock and clock gate.
// - Either clock pin held high holds all stages.
// - Low clear forces every stage to zero at once, overriding everything.
// - On shift, stages two to eight take the prior value of the previous stage.
// - On load, stages one to eight take parallel inputs one to eight.
// - Without clear or qualified edge every stage keeps its value.
`timescale 1ns/1ps
`default_nettype none

module pso_shifter
    import pso_pkg::*;
(
    input  wire logic                  clk_sys,           // System clock, 40 MHz
    input  wire logic                  reset_n,           // Async reset, active low
    input  wire logic                  clear_n,           // Direct clear pin, active low
    input  wire logic                  clock_in,          // Clock pin
    input  wire logic                  clock_gate,        // Clock inhibit pin
    input  wire logic                  shift_sel,         // High shift, low load
    input  wire logic                  serial_in,         // Serial data pin
    input  wire logic [PSO_STAGES-1:0] par_in,            // Parallel data, bit 0 = first input
    input  wire logic                  out_ready,         // Consumer takes queued bit
    output logic                       serial_result_out, // Last stage
    output logic                       stream_valid,      // Queued shifted-out bit present
    output logic                       stream_data        // Oldest shifted-out bit
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    pso_pins_t             pins_meta_q;
    pso_pins_t             pins_q;
    logic                  clear_meta_q;
    logic                  clear_q;
    logic                  int_clk_q;
    logic                  int_clk;
    logic                  clk_edge;
    logic                  stage_rst_n;
    logic                  fifo_ready;
    logic                  fifo_push;
    logic [PSO_STAGES-1:0] stage_q;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pins_meta_q <= PSO_PINS_RST;
            pins_q      <= PSO_PINS_RST;
        end else begin
            pins_meta_q <= '{clock_in: clock_in, clock_gate: clock_gate, shift_sel: shift_sel,
                             serial_in: serial_in, par_in: par_in};
            pins_q      <= pins_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // Clear level seen by the stream side
    // ----------------------------------------------------------------
    // Stages clear asynchronously, but the push is clocked logic and needs a clean level;
    // an edge within two cycles of the clear falling may still queue a 0.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            clear_meta_q <= 1'b1;
            clear_q      <= 1'b1;
        end else begin
            clear_meta_q <= clear_n;
            clear_q      <= clear_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // Internal clock and its rising edge
    // ----------------------------------------------------------------
    assign int_clk  = ~(pins_q.clock_in | pins_q.clock_gate);
    assign clk_edge = int_clk & ~int_clk_q;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            int_clk_q <= 1'b0;
        end else begin
            int_clk_q <= int_clk;
        end
    end

    // ----------------------------------------------------------------
    // Stages
    // ----------------------------------------------------------------
    // Clear joins the reset so it acts without any clock edge
    assign stage_rst_n = reset_n & clear_n;
    // A shift with the queue full is dropped rather than losing a queued bit
    // Edges during clear are lost, and nothing is queued while the synchronised clear (clear_q) is low
    assign fifo_push   = clk_edge & pins_q.shift_sel & clear_q;

    always_ff @(posedge clk_sys or negedge stage_rst_n) begin
        if (!stage_rst_n) begin
            stage_q <= PSO_STAGE_RST;
        end else if (clk_edge) begin
            if (!pins_q.shift_sel) begin
                stage_q <= pins_q.par_in;
            end else if (fifo_ready) begin
                stage_q <= {stage_q[PSO_LAST-1:0], pins_q.serial_in};
            end
        end
    end

    assign serial_result_out = stage_q[PSO_LAST];

    pso_fifo #(
        .W (PSO_FIFO_WIDTH),
        .D (PSO_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .in_valid  (fifo_push),
        .in_ready  (fifo_ready),
        .in_data   (stage_q[PSO_LAST]),
        .out_valid (stream_valid),
        .out_ready (out_ready),
        .out_data  (stream_data)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_shift;
        @(posedge clk_sys) disable iff (!stage_rst_n)
        (clk_edge && pins_q.shift_sel && fifo_ready) |=> stage_q[0] == $past(pins_q.serial_in);
    endproperty
    a_shift: assert property (p_shift) else $error("serial bit not taken into first stage");

    property p_load;
        @(posedge clk_sys) disable iff (!stage_rst_n)
        (clk_edge && !pins_q.shift_sel) |=> stage_q == $past(pins_q.par_in);
    endproperty
    a_load: assert property (p_load) else $error("parallel load mismatch");

    property p_no_serial_on_load;
        @(posedge clk_sys) disable iff (!stage_rst_n)
        (clk_edge && !pins_q.shift_sel && pins_q.serial_in != pins_q.par_in[0])
        |=> stage_q[0] != $past(pins_q.serial_in);
    endproperty
    a_no_serial_on_load: assert property (p_no_serial_on_load) else $error("shift during load");

    property p_clk_rise;
        @(posedge clk_sys) disable iff (!reset_n)
        ($fell(pins_q.clock_in) && !pins_q.clock_gate && !$past(pins_q.clock_gate)) |-> clk_edge;
    endproperty
    a_clk_rise: assert property (p_clk_rise) else $error("clock pin fall missed");

    property p_inhibit;
        @(posedge clk_sys) disable iff (!stage_rst_n)
        (pins_q.clock_in || pins_q.clock_gate) |=> $stable(stage_q);
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("stages moved while inhibited");

    property p_clear;
        @(posedge clk_sys) disable iff (!reset_n)
        !clear_n |-> (stage_q == PSO_STAGE_RST && !serial_result_out);
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not zero stages");

    property p_chain;
        @(posedge clk_sys) disable iff (!stage_rst_n)
        (clk_edge && pins_q.shift_sel && fifo_ready) |=> stage_q[PSO_LAST:1] == $past(stage_q[PSO_LAST-1:0]);
    endproperty
    a_chain: assert property (p_chain) else $error("stage chain broken");

    property p_hold;
        @(posedge clk_sys) disable iff (!stage_rst_n)
        !clk_edge |=> $stable(stage_q);
    endproperty
    a_hold: assert property (p_hold) else $error("stages changed without edge");

    property p_out_last;
        @(posedge clk_sys) disable iff (!stage_rst_n)
        (clk_edge && !pins_q.shift_sel) |=> serial_result_out == $past(pins_q.par_in[PSO_LAST]);
    endproperty
    a_out_last: assert property (p_out_last) else $error("output not eighth stage");

    property p_full_drop;
        @(posedge clk_sys) disable iff (!stage_rst_n)
        (clk_edge && pins_q.shift_sel && !fifo_ready) |=> $stable(stage_q);
    endproperty
    a_full_drop: assert property (p_full_drop) else $error("shift taken while stream full");

    property p_out_shift;
        @(posedge clk_sys) disable iff (!stage_rst_n)
        (clk_edge && pins_q.shift_sel && fifo_ready) |=> serial_result_out == $past(stage_q[PSO_LAST-1]);
    endproperty
    a_out_shift: assert property (p_out_shift) else $error("output missed seventh stage");

    property p_gate_rise;
        @(posedge clk_sys) disable iff (!reset_n)
        ($fell(pins_q.clock_gate) && !pins_q.clock_in && !$past(pins_q.clock_in)) |-> clk_edge;
    endproperty
    a_gate_rise: assert property (p_gate_rise) else $error("gate pin fall missed");

    property p_stream_first;
        @(posedge clk_sys) disable iff (!reset_n)
        (fifo_push && fifo_ready && !stream_valid) |=> (stream_valid && stream_data == $past(stage_q[PSO_LAST]));
    endproperty
    a_stream_first: assert property (p_stream_first) else $error("shifted-out bit not queued");

    c_shift: cover property (@(posedge clk_sys) disable iff (!stage_rst_n)
        clk_edge && pins_q.shift_sel && fifo_ready);
    c_load: cover property (@(posedge clk_sys) disable iff (!stage_rst_n)
        clk_edge && !pins_q.shift_sel);
    c_full: cover property (@(posedge clk_sys) disable iff (!reset_n)
        fifo_push && !fifo_ready);
    c_gate: cover property (@(posedge clk_sys) disable iff (!reset_n)
        $fell(pins_q.clock_gate) && clk_edge);

endmodule

`default_nettype wire

// ### dv/pso_pin_model.sv
/*
 * Model of the system logic that drives the shifter's mode, data and clock pins.
 * Assumes a free-running clk_sys; every pin changes just after a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none

module pso_pin_model
    import pso_pkg::*;
(
    input  wire logic clk_sys, // System clock
    output var pso_pins_t pins // Levels on the device pins
);
    initial pins = PSO_PINS_RST;

    // Four cycles per level: one more than the pin synchronisers need
    task automatic hold4();
        repeat (4) @(posedge clk_sys);
    endtask

    task automatic set_data(input logic shift, input logic ser, input logic [PSO_STAGES-1:0] par);
        pins.shift_sel <= shift;
        pins.serial_in <= ser;
        pins.par_in    <= par;
        hold4();
    endtask

    // The gate only changes while the clock pin rests high
    task automatic set_inhibit(input logic v);
        pins.clock_in   <= 1'b1;
        hold4();
        pins.clock_gate <= v;
        hold4();
    endtask

    task automatic pulse_clock();
        pins.clock_in <= 1'b0;
        hold4();
        pins.clock_in <= 1'b1;
        hold4();
    endtask

    // Clock pin held low, gate pin serves as the clock; raised again with clock high
    task automatic pulse_gate();
        pins.clock_in   <= 1'b0;
        hold4();
        pins.clock_gate <= 1'b0;
        hold4();
        pins.clock_in   <= 1'b1;
        hold4();
        pins.clock_gate <= 1'b1;
        hold4();
    endtask
endmodule

`default_nettype wire

// ### dv/pso_shifter_bench.sv
/*
 * Self-checking bench for the shifter: load, shift, stream back-pressure, clear and clock gating.
 * Assumes the pin model drives the device pins and the bench drives reset, clear and out_ready.
 */
`timescale 1ns/1ps
`default_nettype none

`define CHECK(got, exp, msg) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("MISMATCH at %0t: %s", $time, msg); \
        end \
    end

module pso_shifter_bench;
    import pso_pkg::*;

    localparam logic [PSO_STAGES-1:0] LOAD_VAL = 8'hA5;

    logic      clk_sys   = 1'b0;
    logic      reset_n   = 1'b0;
    logic      clear_n   = 1'b1;
    logic      out_ready = 1'b0;
    pso_pins_t pins;
    logic      serial_result_out;
    logic      stream_valid;
    logic      stream_data;
    int        mismatches = 0;
    int        num_checks = 0;

    always #12.5 clk_sys = ~clk_sys;

    pso_pin_model partner (.clk_sys(clk_sys), .pins(pins));

    pso_shifter dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .clear_n(clear_n),
        .clock_in(pins.clock_in), .clock_gate(pins.clock_gate), .shift_sel(pins.shift_sel),
        .serial_in(pins.serial_in), .par_in(pins.par_in), .out_ready(out_ready),
        .serial_result_out(serial_result_out), .stream_valid(stream_valid), .stream_data(stream_data)
    );

    task automatic tally_and_finish();
        if (mismatches == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Serial bit 0 on the first shift, then 1: a ninth shift taken would show a 1
    task automatic t_load_shift_fill();
        partner.set_inhibit(1'b0);
        partner.set_data(1'b0, 1'b0, LOAD_VAL);
        partner.pulse_clock();
        `CHECK(serial_result_out, LOAD_VAL[7], "load eighth bit")
        for (int k = 1; k <= 9; k++) begin
            partner.set_data(1'b1, (k != 1), 8'hFF);
            partner.pulse_clock();
            `CHECK(serial_result_out, (k < 8) ? LOAD_VAL[7-k] : 1'b0, "shift step")
        end
        `CHECK(stream_valid, 1'b1, "stream full")
    endtask

    task automatic t_drain_retry();
        for (int i = 7; i >= 0; i--) begin
            `CHECK(stream_data, LOAD_VAL[i], "stream order")
            out_ready <= 1'b1;
            @(posedge clk_sys);
            out_ready <= 1'b0;
            @(posedge clk_sys);
        end
        `CHECK(stream_valid, 1'b0, "stream drained")
        partner.pulse_clock();
        `CHECK(serial_result_out, 1'b1, "retried shift")
        `CHECK(stream_data, 1'b0, "first serial bit out")
    endtask

    // Clear must win at once, even over a load edge
    task automatic t_clear();
        clear_n <= 1'b0;
        #2;
        `CHECK(serial_result_out, 1'b0, "clear immediate")
        @(posedge clk_sys);
        partner.set_data(1'b1, 1'b1, 8'h00);
        partner.pulse_clock();
        `CHECK(serial_result_out, 1'b0, "clear overrides shift")
        partner.set_data(1'b0, 1'b0, 8'hFF);
        partner.pulse_clock();
        `CHECK(serial_result_out, 1'b0, "clear overrides load")
        clear_n   <= 1'b1;
        out_ready <= 1'b1;
        @(posedge clk_sys);
        out_ready <= 1'b0;
        @(posedge clk_sys);
        `CHECK(stream_valid, 1'b0, "no bit queued under clear")
    endtask

    task automatic t_hold_gate();
        partner.set_inhibit(1'b1);
        partner.pulse_clock();
        `CHECK(serial_result_out, 1'b0, "inhibited edge ignored")
        partner.pulse_gate();
        `CHECK(serial_result_out, 1'b1, "gate pin clocks load")
    endtask

    initial begin
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        `CHECK(serial_result_out, 1'b0, "after reset")
        t_load_shift_fill();
        t_drain_retry();
        t_clear();
        t_hold_gate();
        tally_and_finish();
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        tally_and_finish();
    end
endmodule

`default_nettype wire
